/* sst_pkg.sv */
// Constants and types for the converter start and tracking control block
package sst_pkg;
   // Register indices; byte address is four times the index
   localparam logic [9:0] IDX_CTRL   = 10'h0AA;
   localparam logic [9:0] IDX_CFG    = 10'h0AB;
   localparam logic [9:0] IDX_RESULT = 10'h0B0;
   localparam logic [9:0] IDX_IRQEN  = 10'h0B1;
   localparam int unsigned ADDR_W    = 12;
   // Control register fields
   localparam int unsigned BIT_ON    = 7;
   localparam int unsigned BIT_LPT   = 6;
   localparam int unsigned BIT_DONE  = 5;
   localparam int unsigned BIT_BUSY  = 4;
   localparam int unsigned SRC_LSB   = 1;
   localparam int unsigned SRC_MSB   = 3;
   // Configuration register fields
   localparam int unsigned DIV_LSB   = 3;
   localparam int unsigned DIV_MSB   = 7;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] CFG_RESET  = 8'hF8;
   localparam logic [7:0] CFG_MASK   = 8'hFB;
   // Start source codes
   localparam logic [2:0] SRC_SW  = 3'h0;
   localparam logic [2:0] SRC_T3  = 3'h1;
   localparam logic [2:0] SRC_EXT = 3'h2;
   localparam logic [2:0] SRC_T2  = 3'h3;
   // Sequence lengths in SAR clocks
   localparam logic [2:0] TRACK_TICKS = 3'h3;
   localparam logic [2:0] LAST_BIT    = 3'h7;
   localparam logic [7:0] FIRST_TRIAL = 8'h80;
   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_TRACK = 2'b01,
      ST_CONV  = 2'b11
   } sst_state_t;
endpackage

/* sst_ctrl.sv */
// Start, tracking and SAR sequencing for the 8-bit converter
//
// Local design decision: the APB slave port.
`timescale 1ns/10ps
`default_nettype none
module sst_ctrl (
   input  wire logic                      CLOCK,
   input  wire logic                      NRST,
   input  wire logic                      PSEL,
   input  wire logic                      PENABLE,
   input  wire logic                      PWRITE,
   input  wire logic [sst_pkg::ADDR_W-1:0] PADDR,
   input  wire logic [31:0]               PWDATA,
   output logic      [31:0]               PRDATA,
   output logic                           PREADY,
   output logic                           PSLVERR,
   input  wire logic                      TIMER3_OVF,
   input  wire logic                      TIMER2_OVF,
   input  wire logic                      COMPANION_START,
   input  wire logic                      EXT_STROBE,
   input  wire logic                      COMP_ABOVE,
   output logic                           CONVERTER_ON,
   output logic                           TRACK_ENABLE,
   output logic      [7:0]                TRIAL_CODE,
   output logic                           CONV_BUSY,
   output logic                           DONE_FLAG,
   output logic                           IRQ
);
   sst_pkg::sst_state_t st_q, st_d;
   logic       on_q, lpt_q, done_q, ie_q, track_q, irq_q;
   logic [2:0] src_q;
   logic [7:0] cfg_q, result_q, trial_q;
   logic [4:0] div_cnt_q;
   logic [2:0] ph_q;
   logic       ext_s1_q, ext_s2_q, ext_s3_q;
   logic       pready_q, pslverr_q;
   logic [31:0] prdata_q;
   logic       setup, acc_wr, hit_ctrl, hit_cfg, hit_res, hit_ie, hit_any;
   logic       sw_go, ext_rise, trig, start, tick, last_tick, trk_end;
   logic [7:0] sar_bit, conv_code_d;

   // Two flops before the strobe is looked at, third one for edge finding
   always_ff @(posedge CLOCK or negedge NRST) begin
      if (!NRST) begin
         ext_s1_q <= 1'b0;
         ext_s2_q <= 1'b0;
         ext_s3_q <= 1'b0;
      end else begin
         ext_s1_q <= EXT_STROBE;
         ext_s2_q <= ext_s1_q;
         ext_s3_q <= ext_s2_q;
      end
   end
   assign ext_rise = ext_s2_q & ~ext_s3_q;

   // Address decode; low address bits must be zero for a word hit
   assign setup    = PSEL & ~PENABLE;
   assign hit_ctrl = (PADDR[11:2] == sst_pkg::IDX_CTRL)
                     && (PADDR[1:0] == 2'h0);
   assign hit_cfg  = (PADDR[11:2] == sst_pkg::IDX_CFG) && (PADDR[1:0] == 2'h0);
   assign hit_res  = (PADDR[11:2] == sst_pkg::IDX_RESULT)
                     && (PADDR[1:0] == 2'h0);
   assign hit_ie   = (PADDR[11:2] == sst_pkg::IDX_IRQEN)
                     && (PADDR[1:0] == 2'h0);
   assign hit_any  = hit_ctrl | hit_cfg | hit_res | hit_ie;
   assign acc_wr   = PSEL & PENABLE & pready_q & PWRITE & ~pslverr_q;

   // Ready rises in the first access cycle, so every transfer has no wait
   always_ff @(posedge CLOCK or negedge NRST) begin
      if (!NRST) begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= 32'h00000000;
      end else begin
         pready_q  <= setup;
         pslverr_q <= setup & ~hit_any;
         prdata_q  <= 32'h00000000;
         if (setup && !PWRITE) begin
            if (hit_ctrl) begin
               // Bit 0 has no storage and always reads zero
               prdata_q[7:0] <= {on_q, lpt_q, done_q, CONV_BUSY,
                                 src_q, 1'b0};
            end else if (hit_cfg) begin
               prdata_q[7:0] <= cfg_q;
            end else if (hit_res) begin
               prdata_q[7:0] <= result_q;
            end else if (hit_ie) begin
               prdata_q[0] <= ie_q;
            end
         end
      end
   end

   // Control fields; the busy bit is not stored, a write of one is a command
   always_ff @(posedge CLOCK or negedge NRST) begin
      if (!NRST) begin
         on_q  <= sst_pkg::CTRL_RESET[sst_pkg::BIT_ON];
         lpt_q <= sst_pkg::CTRL_RESET[sst_pkg::BIT_LPT];
         src_q <= sst_pkg::CTRL_RESET[sst_pkg::SRC_MSB:sst_pkg::SRC_LSB];
      end else if (acc_wr && hit_ctrl) begin
         on_q  <= PWDATA[sst_pkg::BIT_ON];
         lpt_q <= PWDATA[sst_pkg::BIT_LPT];
         src_q <= PWDATA[sst_pkg::SRC_MSB:sst_pkg::SRC_LSB];
      end
   end

   // Divider setting and gain bits; bit 2 has no storage
   always_ff @(posedge CLOCK or negedge NRST) begin
      if (!NRST) begin
         cfg_q <= sst_pkg::CFG_RESET;
         ie_q  <= 1'b0;
      end else begin
         if (acc_wr && hit_cfg) begin
            cfg_q <= PWDATA[7:0] & sst_pkg::CFG_MASK;
         end
         if (acc_wr && hit_ie) begin
            ie_q <= PWDATA[0];
         end
      end
   end

   // Completion flag: a completion in the clearing cycle wins over the clear
   always_ff @(posedge CLOCK or negedge NRST) begin
      if (!NRST) begin
         done_q <= 1'b0;
      end else if (last_tick) begin
         done_q <= 1'b1;
      end else if (acc_wr && hit_ctrl) begin
         done_q <= PWDATA[sst_pkg::BIT_DONE];
      end
   end

   // The start bit acts with the source code already held, not the one
   // written in the same transfer
   assign sw_go = acc_wr & hit_ctrl & PWDATA[sst_pkg::BIT_BUSY];

   // Start trigger chosen by the source field
   always_comb begin
      trig = 1'b0;
      if (src_q[2]) begin
         trig = COMPANION_START;
      end else begin
         unique case (src_q[1:0])
            2'h0: trig = sw_go;
            2'h1: trig = TIMER3_OVF;
            2'h2: trig = ext_rise;
            2'h3: trig = TIMER2_OVF;
         endcase
      end
   end

   // Only an enabled, idle converter takes a trigger
   assign start = on_q & (st_q == sst_pkg::ST_IDLE) & trig;

   // SAR clock enable: one tick every divider+1 system clocks
   assign tick      = (div_cnt_q == cfg_q[sst_pkg::DIV_MSB:sst_pkg::DIV_LSB]);
   assign trk_end   = (st_q == sst_pkg::ST_TRACK) & tick
                      & (ph_q == sst_pkg::TRACK_TICKS - 3'h1);
   assign last_tick = on_q & (st_q == sst_pkg::ST_CONV) & tick
                      & (ph_q == sst_pkg::LAST_BIT);

   // Sequence: idle, optional three tick track, eight tick conversion
   always_comb begin
      st_d = st_q;
      unique case (st_q)
         sst_pkg::ST_IDLE: begin
            if (start) begin
               // Strobe mode already tracked while the strobe was low
               if (lpt_q && (src_q != sst_pkg::SRC_EXT)) begin
                  st_d = sst_pkg::ST_TRACK;
               end else begin
                  st_d = sst_pkg::ST_CONV;
               end
            end
         end
         sst_pkg::ST_TRACK: begin
            if (trk_end) begin
               st_d = sst_pkg::ST_CONV;
            end
         end
         sst_pkg::ST_CONV: begin
            if (last_tick) begin
               st_d = sst_pkg::ST_IDLE;
            end
         end
         default: st_d = sst_pkg::ST_IDLE;
      endcase
      // Disabling aborts any sequence without setting the done flag
      if (!on_q) begin
         st_d = sst_pkg::ST_IDLE;
      end
   end

   always_ff @(posedge CLOCK or negedge NRST) begin
      if (!NRST) begin
         st_q <= sst_pkg::ST_IDLE;
      end else begin
         st_q <= st_d;
      end
   end

   // Divider and phase restart on each state change so ticks stay aligned
   always_ff @(posedge CLOCK or negedge NRST) begin
      if (!NRST) begin
         div_cnt_q <= 5'h00;
         ph_q      <= 3'h0;
      end else if (st_d != st_q || st_q == sst_pkg::ST_IDLE) begin
         div_cnt_q <= 5'h00;
         ph_q      <= 3'h0;
      end else if (tick) begin
         div_cnt_q <= 5'h00;
         ph_q      <= ph_q + 3'h1;
      end else begin
         div_cnt_q <= div_cnt_q + 5'h01;
      end
   end

   // Successive approximation: keep or drop the bit on trial, try the next
   assign sar_bit     = sst_pkg::FIRST_TRIAL >> ph_q;
   assign conv_code_d = (trial_q & ~sar_bit) | (COMP_ABOVE ? sar_bit : 8'h00)
                        | (sar_bit >> 1);

   always_ff @(posedge CLOCK or negedge NRST) begin
      if (!NRST) begin
         trial_q  <= 8'h00;
         result_q <= 8'h00;
      end else begin
         if (st_d == sst_pkg::ST_CONV && st_q != sst_pkg::ST_CONV) begin
            trial_q <= sst_pkg::FIRST_TRIAL;
         end else if (st_q == sst_pkg::ST_CONV && tick) begin
            trial_q <= conv_code_d;
         end
         if (last_tick) begin
            result_q <= conv_code_d;
         end
      end
   end

   // Track switch: closed whenever enabled and idle in normal mode, limited in low power mode
   always_ff @(posedge CLOCK or negedge NRST) begin
      if (!NRST) begin
         track_q <= 1'b0;
      end else if (!on_q) begin
         track_q <= 1'b0;
      end else if (st_d == sst_pkg::ST_IDLE) begin
         track_q <= ~lpt_q
                    | ((src_q == sst_pkg::SRC_EXT) & ~ext_s2_q);
      end else begin
         track_q <= (st_d == sst_pkg::ST_TRACK);
      end
   end

   // Interrupt request follows the flag so it stays until software clears
   always_ff @(posedge CLOCK or negedge NRST) begin
      if (!NRST) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= ie_q & (done_q | last_tick);
      end
   end

   assign PRDATA       = prdata_q;
   assign PREADY       = pready_q;
   assign PSLVERR      = pslverr_q;
   assign CONVERTER_ON = on_q;
   assign TRACK_ENABLE = track_q;
   assign TRIAL_CODE   = trial_q;
   assign CONV_BUSY    = (st_q != sst_pkg::ST_IDLE);
   assign DONE_FLAG    = done_q;
   assign IRQ          = irq_q;

   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (!NRST);

   a_off_no_busy:
      assert property (!on_q |=> !CONV_BUSY)
      else $error("busy while disabled");
   a_done_on_fall:
      assert property ($fell(CONV_BUSY) && $past(on_q) |-> DONE_FLAG)
      else $error("done flag not set at busy fall");
   a_done_sticky:
      assert property (DONE_FLAG && !(acc_wr && hit_ctrl) |=> DONE_FLAG)
      else $error("done flag cleared by hardware");
   a_sw_start:
      assert property (on_q && !CONV_BUSY && src_q == sst_pkg::SRC_SW
                       && sw_go |=> CONV_BUSY)
      else $error("software start lost");
   a_timer_start:
      assert property (on_q && !CONV_BUSY && src_q == sst_pkg::SRC_T3
                       && TIMER3_OVF |=> CONV_BUSY)
      else $error("timer three start lost");
   a_timer2_start:
      assert property (on_q && !CONV_BUSY && src_q == sst_pkg::SRC_T2
                       && TIMER2_OVF |=> CONV_BUSY)
      else $error("timer two start lost");
   a_companion_start:
      assert property (on_q && !CONV_BUSY && src_q[2] && COMPANION_START
                       |=> CONV_BUSY)
      else $error("companion start lost");
   a_idle_holds:
      assert property (st_q == sst_pkg::ST_IDLE && !start
                       |=> st_q == sst_pkg::ST_IDLE)
      else $error("start without trigger");
   a_lp_tracks:
      assert property (start && lpt_q && src_q != sst_pkg::SRC_EXT
                       |=> st_q == sst_pkg::ST_TRACK && TRACK_ENABLE)
      else $error("low power start skipped tracking");
   a_conv_length:
      assert property ($rose(st_q == sst_pkg::ST_CONV) && on_q
                       && cfg_q[7:3] == 5'h00 && !(acc_wr && hit_cfg)
                       |-> (st_q == sst_pkg::ST_CONV)[*8]
                       ##1 (st_q == sst_pkg::ST_IDLE))
      else $error("conversion not eight SAR clocks");
   a_result_load:
      assert property (last_tick |=> result_q == $past(conv_code_d))
      else $error("result not loaded at end");
   a_bit0_zero:
      assert property (setup && hit_ctrl && !PWRITE |=> PRDATA[0] == 1'b0)
      else $error("unused control bit reads one");

   // Tracking switch, flag sources and trigger handling
   a_off_no_track:
      assert property (!on_q |=> !TRACK_ENABLE)
      else $error("tracking while disabled");
   a_normal_tracks:
      assert property (on_q && !lpt_q && st_d == sst_pkg::ST_IDLE
                       |=> TRACK_ENABLE)
      else $error("normal mode idle without tracking");
   a_conv_holds:
      assert property (st_q == sst_pkg::ST_CONV |-> !TRACK_ENABLE)
      else $error("tracking during conversion");
   a_done_only:
      assert property (!DONE_FLAG && !last_tick
                       && !(acc_wr && hit_ctrl && PWDATA[sst_pkg::BIT_DONE])
                       |=> !DONE_FLAG)
      else $error("done flag set without completion");
   a_done_wins:
      assert property (last_tick |=> DONE_FLAG)
      else $error("completion lost against a clear");
   a_zero_write:
      assert property (acc_wr && hit_ctrl && !PWDATA[sst_pkg::BIT_BUSY]
                       && !CONV_BUSY && src_q == sst_pkg::SRC_SW
                       |=> !CONV_BUSY)
      else $error("busy write of zero started a conversion");
   a_strobe_start:
      assert property (on_q && !CONV_BUSY && src_q == sst_pkg::SRC_EXT
                       && ext_rise |=> CONV_BUSY)
      else $error("strobe start lost");
   a_strobe_direct:
      assert property (start && lpt_q && src_q == sst_pkg::SRC_EXT
                       |=> st_q == sst_pkg::ST_CONV)
      else $error("strobe start tracked first");
   a_strobe_track:
      assert property (on_q && lpt_q && src_q == sst_pkg::SRC_EXT
                       && st_d == sst_pkg::ST_IDLE
                       |=> TRACK_ENABLE != $past(ext_s2_q))
      else $error("strobe mode tracking not following strobe");
   // Cycle-exact length checks hold only while divider and enable stay put
   a_track_three:
      assert property ($rose(st_q == sst_pkg::ST_TRACK) && on_q
                       && cfg_q[7:3] == 5'h00 && !(acc_wr && hit_cfg)
                       |-> (st_q == sst_pkg::ST_TRACK)[*3]
                       ##1 (st_q == sst_pkg::ST_CONV))
      else $error("tracking phase not three SAR clocks");
   a_no_restart:
      assert property (st_q == sst_pkg::ST_CONV && on_q && !tick
                       |=> st_q == sst_pkg::ST_CONV && ph_q == $past(ph_q))
      else $error("trigger restarted a conversion");
   a_trial_first:
      assert property ($rose(st_q == sst_pkg::ST_CONV)
                       |-> TRIAL_CODE == sst_pkg::FIRST_TRIAL)
      else $error("conversion did not try the top bit first");
   a_irq_level:
      assert property (ie_q && DONE_FLAG |=> IRQ)
      else $error("interrupt request missing");
endmodule
`default_nettype wire

/* sst_front_model.sv */
// Track-and-hold and comparator model on the converter's analog side
`timescale 1ns/10ps
`default_nettype none
module sst_front_model (
   input  wire logic       CLOCK,
   input  wire logic [7:0] VIN,
   input  wire logic       TRACK_ENABLE,
   input  wire logic [7:0] TRIAL_CODE,
   output logic            COMP_ABOVE
);
   logic [7:0] held_q;

   // Hold level follows the input only while the track switch is closed,
   // so a stale sample shows up if tracking is skipped
   always_ff @(posedge CLOCK) begin
      if (TRACK_ENABLE) begin
         held_q <= VIN;
      end
   end

   // Trial kept when the held level reaches it: straight binary result
   assign COMP_ABOVE = (held_q >= TRIAL_CODE);
endmodule
`default_nettype wire

/* sst_ctrl_tb.sv */
// Self-checking bench for the converter start and tracking control
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin \
 bad_count++; $display("Error %s expected %0h seen %0h", nm, ex, got); \
 end end
module sst_ctrl_tb;
   logic        clock = 1'b0;
   logic        nrst = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h00000000;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [2:0]  pulse = 3'h0;
   logic        strobe = 1'b0;
   logic        comp_above;
   logic        conv_on;
   logic        track_en;
   logic [7:0]  trial;
   logic        busy;
   logic        done;
   logic        irq;
   logic [7:0]  vin = 8'h00;
   logic [31:0] rd;
   logic        err;
   logic [7:0]  ctl;
   logic [7:0]  tbl [3] = '{8'h00, 8'h80, 8'hFF};
   int          bad_count = 0;
   int          cmp_count = 0;
   int          cyc = 0;
   int          exp_q [$];
   int          div;

   always #5 clock = ~clock;

   sst_ctrl dut_u (
      .CLOCK(clock), .NRST(nrst), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
      .PREADY(pready), .PSLVERR(pslverr), .TIMER3_OVF(pulse[0]),
      .TIMER2_OVF(pulse[1]), .COMPANION_START(pulse[2]),
      .EXT_STROBE(strobe), .COMP_ABOVE(comp_above),
      .CONVERTER_ON(conv_on), .TRACK_ENABLE(track_en),
      .TRIAL_CODE(trial), .CONV_BUSY(busy), .DONE_FLAG(done), .IRQ(irq));

   sst_front_model model_u (
      .CLOCK(clock), .VIN(vin), .TRACK_ENABLE(track_en),
      .TRIAL_CODE(trial), .COMP_ABOVE(comp_above));

   // Verdict and end of run, also reached from the hang guard
   task automatic stop_test();
      $display("Compared %0d, mismatched %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // One APB transfer; answer taken at the edge that completes it
   task automatic apb(input logic wr, input logic [9:0] idx,
                      input logic [7:0] wd);
      int n;
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {idx, 2'b00};
      pwdata <= {24'h000000, wd};
      @(posedge clock);
      penable <= 1'b1;
      n = 0;
      // Wait for ready at a rising edge; data and error taken there
      do begin
         @(posedge clock);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1) begin
         bad_count++;
         $display("Error apb ready expected 1 seen %0h", pready);
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // Raise one start source: 0 software, 1 T3, 2 strobe, 3 T2, 4 companion
   task automatic fire(input int code, input logic [7:0] c);
      @(posedge clock);
      case (code)
         0: apb(1'b1, sst_pkg::IDX_CTRL, c | 8'h10);
         2: begin
            strobe <= 1'b0;
            repeat (2) @(posedge clock);
            strobe <= 1'b1;
         end
         default: begin
            pulse[code == 1 ? 0 : code == 3 ? 1 : 2] <= 1'b1;
            @(posedge clock);
            pulse <= 3'h0;
         end
      endcase
   endtask

   // Start, retrigger mid-sequence, then check length, flags and result
   task automatic run(input int code, input int len_x);
      int n;
      int len;
      int e;
      fire(code, ctl);
      n = 0;
      #1;
      while (busy !== 1'b1 && n < 10) begin
         @(posedge clock);
         #1;
         n++;
      end
      len = 0;
      fork
         while (busy === 1'b1 && len < 900) begin
            @(posedge clock);
            #1;
            len++;
         end
         fire(code, ctl);
      join
      `CHK("busy length", len_x, len)
      `CHK("done flag", 1'b1, done)
      @(posedge clock);
      #1;
      `CHK("irq", 1'b1, irq)
      apb(1'b0, sst_pkg::IDX_CTRL, 8'h00);
      `CHK("ctrl after", {24'h0, ctl | 8'h20}, rd)
      e = exp_q.pop_front();
      apb(1'b0, sst_pkg::IDX_RESULT, 8'h00);
      `CHK("result", 32'(e), rd)
      strobe <= 1'b0;
   endtask

   // Hang guard well above the expected run of under a thousand cycles
   always @(posedge clock) begin
      cyc++;
      if (cyc == 20000) begin
         bad_count++;
         stop_test();
      end
   end

   // Main sequence
   initial begin
      void'($urandom(32'hC11525BD));
      repeat (2) @(posedge clock);
      nrst <= 1'b1;
      apb(1'b0, sst_pkg::IDX_CTRL, 8'h00);
      `CHK("ctrl reset", 32'h00000000, rd)
      apb(1'b0, sst_pkg::IDX_CFG, 8'h00);
      `CHK("cfg reset", 32'h000000F8, rd)
      apb(1'b0, 10'h0A0, 8'h00);
      `CHK("unmapped error", 1'b1, err)
      apb(1'b1, sst_pkg::IDX_CTRL, 8'h10);
      repeat (6) @(posedge clock);
      `CHK("busy while off", 1'b0, busy)
      `CHK("on while off", 1'b0, conv_on)
      apb(1'b1, sst_pkg::IDX_IRQEN, 8'h01);
      // Every source code in both track modes, random divider
      for (int t = 0; t < 10; t++) begin
         // Divider zero once per mode so the cycle-exact checks are reached
         div = (t % 5 == 0) ? 0 : $urandom_range(2);
         ctl = 8'(8'h80 | ((t / 5) << 6) | ((t % 5) << 1));
         // Companion code with random low bits picks one code of 1xx per mode
         if (t % 5 == 4) begin
            ctl = ctl | 8'($urandom_range(3) << 1);
         end
         vin <= t < 3 ? tbl[t] : 8'($urandom_range(255));
         apb(1'b1, sst_pkg::IDX_CFG, 8'(div << 3));
         apb(1'b1, sst_pkg::IDX_CTRL, ctl | 8'h01);
         apb(1'b0, sst_pkg::IDX_CTRL, 8'h00);
         `CHK("ctrl written", {24'h0, ctl}, rd)
         `CHK("converter on", 1'b1, conv_on)
         `CHK("irq cleared", 1'b0, irq)
         exp_q.push_back(int'(vin));
         fire((t % 5 + 1) % 5, ctl);
         repeat (5) @(posedge clock);
         `CHK("other source", 1'b0, busy)
         run(t % 5, ((t >= 5 && t % 5 != 2) ? 11 : 8) * (div + 1));
         $display("Test %0d finished", t);
      end
      stop_test();
   end
endmodule
`default_nettype wire
